// File: core/host_port_params.svh
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

`define ADDR_WIDTH 7
`define DATA_WIDTH 8
`define MEM_DEPTH 128
`define CLK_PERIOD_NS 100
`define ACK_MIN_NS 310
`define ACK_MAX_NS 472
`define DATA_VALID_MAX_NS 177
// Least time rounds up, longest rounds down
`define ACK_MIN_CYC ((`ACK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACK_MAX_CYC (`ACK_MAX_NS / `CLK_PERIOD_NS)
`define DATA_VALID_CYC (`DATA_VALID_MAX_NS / `CLK_PERIOD_NS)
// Wait length chosen inside the window
`define WAIT_CYC 4
`define WAIT_CNT_WIDTH 3

`endif

// File: core/host_port_pkg.sv
`default_nettype none
package host_port_pkg;
	typedef enum logic [1:0] {
		idle_state,
		wait_state,
		done_state
	} port_state_type;
	typedef enum logic {
		mode_strobed,
		mode_split
	} bus_mode_type;
endpackage : host_port_pkg
`default_nettype wire

// File: core/parallel_host_bus_port.sv
// Function
// - Strobed mode: address, data, direction, chip select
// - Split mode: chip select, read and write strobes
// - Acknowledge high at select, low after wait
// - Strobed read data valid, released on deselect
// - Ready driven once chip select falls
// - Ready low after strobe, high after wait
// - Split read data valid, released after strobe
// - Ready released when chip select rises
`include "host_port_params.svh"
`default_nettype none
module parallel_host_bus_port (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire host_port_pkg::bus_mode_type bus_mode,
	input wire logic chip_select_low_n,
	input wire logic read_strobe_low_n,
	input wire logic write_strobe_or_direction,
	input wire logic [`ADDR_WIDTH-1:0] addr_in,
	input wire logic [`DATA_WIDTH-1:0] data_in,
	output logic [`DATA_WIDTH-1:0] data_out,
	output logic data_oe,
	output logic transfer_acknowledge,
	output logic transfer_acknowledge_oe
);
	import host_port_pkg::*;

	// Pins are asynchronous to sys_clk
	logic [3:0] pin_meta_reg;
	logic [3:0] pin_sync_reg;
	logic [`ADDR_WIDTH-1:0] addr_meta_reg;
	logic [`ADDR_WIDTH-1:0] addr_sync_reg;
	logic [`DATA_WIDTH-1:0] data_meta_reg;
	logic [`DATA_WIDTH-1:0] data_sync_reg;
	logic [`DATA_WIDTH-1:0] data_hold_reg;
	logic [`ADDR_WIDTH-1:0] addr_hold_reg;
	logic write_hold_reg;
	port_state_type state_reg;
	port_state_type state_next;
	logic [`WAIT_CNT_WIDTH-1:0] wait_reg;
	logic [`WAIT_CNT_WIDTH-1:0] wait_next;
	logic ack_next;
	logic ack_oe_next;
	logic data_oe_next;
	logic [`DATA_WIDTH-1:0] read_data;

	wire selected = ~pin_sync_reg[0];
	wire read_low = ~pin_sync_reg[1];
	wire write_pin = pin_sync_reg[2];
	wire was_write_pin = pin_sync_reg[3];
	wire split_mode = (bus_mode == mode_split);
	wire split_write_low = split_mode & ~write_pin;
	wire split_active = selected & (read_low | split_write_low);
	wire strobed_active = ~split_mode & selected;
	wire access_active = split_mode ? split_active : strobed_active;
	// Direction sampled when the access starts (select in strobed mode, strobe in split mode), held through the access
	wire start_is_write = split_mode ? split_write_low : ~write_pin;
	wire wait_done = (wait_reg == `WAIT_CNT_WIDTH'(`WAIT_CYC - 1));
	// Write commits when the strobe or select goes away
	wire commit_write = (state_reg != idle_state) & ~access_active & write_hold_reg;
	wire [`ADDR_WIDTH-1:0] mem_addr = (state_reg == idle_state) ? addr_sync_reg : addr_hold_reg;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta_reg <= 4'hF;
			pin_sync_reg <= 4'hF;
		end else begin
			pin_meta_reg <= {pin_meta_reg[2], write_strobe_or_direction,
				read_strobe_low_n, chip_select_low_n};
			pin_sync_reg <= {pin_sync_reg[2], pin_meta_reg[2:0]};
		end
	end

	always_ff @(posedge sys_clk) begin
		addr_meta_reg <= addr_in;
		addr_sync_reg <= addr_meta_reg;
		data_meta_reg <= data_in;
		data_sync_reg <= data_meta_reg;
		if (access_active) begin
			data_hold_reg <= data_sync_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		wait_next = wait_reg;
		unique case (state_reg)
			idle_state: begin
				wait_next = '0;
				if (access_active) begin
					state_next = wait_state;
				end
			end
			wait_state: begin
				if (!access_active) begin
					state_next = idle_state;
				end else if (wait_done) begin
					state_next = done_state;
				end else begin
					wait_next = wait_reg + 1'b1;
				end
			end
			done_state: begin
				if (!access_active) begin
					state_next = idle_state;
				end
			end
		endcase
	end

	// Ack polarity: strobed mode high while busy, split mode low while busy
	assign ack_next = split_mode ? ~(state_next == wait_state) : (state_next == wait_state);
	assign ack_oe_next = selected;
	// Read data driven only after the memory has answered
	assign data_oe_next = access_active & ~start_is_write & (state_reg != idle_state);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= idle_state;
			wait_reg <= '0;
			write_hold_reg <= 1'b0;
			addr_hold_reg <= '0;
			transfer_acknowledge <= 1'b0;
			transfer_acknowledge_oe <= 1'b0;
			data_oe <= 1'b0;
			data_out <= '0;
		end else begin
			state_reg <= state_next;
			wait_reg <= wait_next;
			if (state_reg == idle_state && access_active) begin
				write_hold_reg <= start_is_write;
				addr_hold_reg <= addr_sync_reg;
			end
			transfer_acknowledge <= ack_next;
			transfer_acknowledge_oe <= ack_oe_next;
			data_oe <= data_oe_next;
			data_out <= read_data;
		end
	end

	port_memory memory_inst (
		.sys_clk(sys_clk),
		.write_en(commit_write),
		.addr(mem_addr),
		.write_data(data_hold_reg),
		.read_data(read_data)
	);
endmodule : parallel_host_bus_port
`default_nettype wire

// File: core/port_memory.sv
`include "host_port_params.svh"
`default_nettype none
module port_memory (
	input wire logic sys_clk,
	input wire logic write_en,
	input wire logic [`ADDR_WIDTH-1:0] addr,
	input wire logic [`DATA_WIDTH-1:0] write_data,
	output logic [`DATA_WIDTH-1:0] read_data
);
	logic [`DATA_WIDTH-1:0] store [`MEM_DEPTH];

	always_ff @(posedge sys_clk) begin
		if (write_en) begin
			store[addr] <= write_data;
		end
		read_data <= store[addr];
	end
endmodule : port_memory
`default_nettype wire

// File: test/host_model.sv
`include "host_port_params.svh"
`default_nettype none
module host_model (
	input wire logic sys_clk,
	input wire logic transfer_acknowledge,
	input wire logic transfer_acknowledge_oe,
	input wire logic [`DATA_WIDTH-1:0] data_out,
	output host_port_pkg::bus_mode_type bus_mode,
	output logic chip_select_low_n,
	output logic read_strobe_low_n,
	output logic write_strobe_or_direction,
	output logic [`ADDR_WIDTH-1:0] addr_in,
	output logic [`DATA_WIDTH-1:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	import host_port_pkg::*;
	initial begin
		{chip_select_low_n, read_strobe_low_n, write_strobe_or_direction} = 3'h7;
		bus_mode = mode_strobed;
		addr_in = '0;
		data_in = '0;
	end
	task automatic xfer(input bus_mode_type m, input logic w, input logic [`ADDR_WIDTH-1:0] a,
		input logic [`DATA_WIDTH-1:0] d, output logic [`DATA_WIDTH-1:0] q, output logic ok);
		int n;
		n = 0;
		@(negedge sys_clk);
		bus_mode = m;
		// Idle data lines flip so stale data never passes
		data_in = ~data_in;
		repeat (5) @(negedge sys_clk);
		addr_in = a;
		write_strobe_or_direction = !w;
		if (w) data_in = d;
		chip_select_low_n = 1'b0;
		read_strobe_low_n = (m == mode_strobed) | w;
		// Sample mid-cycle, away from the edge that launches the answer
		do @(negedge sys_clk) n++;
		while (n < 20 && !(transfer_acknowledge_oe && transfer_acknowledge === m));
		q = data_out;
		ok = n < 20;
		@(negedge sys_clk);
		chip_select_low_n = 1'b1;
		read_strobe_low_n = 1'b1;
		write_strobe_or_direction |= (m == mode_split);
	endtask : xfer
endmodule : host_model
`default_nettype wire

// File: test/host_port_assertions.sv
`default_nettype none
module host_port_checker (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire host_port_pkg::bus_mode_type bus_mode,
	input wire logic chip_select_low_n,
	input wire logic write_strobe_or_direction,
	input wire logic data_oe,
	input wire logic transfer_acknowledge,
	input wire logic transfer_acknowledge_oe
);
	import host_port_pkg::*;
	wire cs = chip_select_low_n;
	wire ak = transfer_acknowledge;
	wire ao = transfer_acknowledge_oe;
	wire m = bus_mode == mode_split;
	wire dr = write_strobe_or_direction;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	property p_on; $fell(cs) |-> ##[2:4] ao; endproperty
	a_on: assert property (p_on) else $error("ack late");
	property p_hi; !m && $rose(ao) |-> ak; endproperty
	a_hi: assert property (p_hi) else $error("ack low");
	property p_sw; !m && $rose(ak) |-> ak [*4] ##1 !ak; endproperty
	a_sw: assert property (p_sw) else $error("ack len");
	property p_rw; m && $fell(ak) |-> !ak [*4] ##1 ak; endproperty
	a_rw: assert property (p_rw) else $error("ready len");
	property p_off; $rose(cs) |-> ##[2:4] !ao; endproperty
	a_off: assert property (p_off) else $error("ack held");
	property p_rd; !m && dr && $fell(cs) |-> ##[3:5] data_oe; endproperty
	a_rd: assert property (p_rd) else $error("no data");
	property p_wr; !m && !dr && !cs |-> !data_oe; endproperty
	a_wr: assert property (p_wr) else $error("drive on write");
	property p_rel; $rose(cs) |-> ##[1:4] !data_oe; endproperty
	a_rel: assert property (p_rel) else $error("data held");
endmodule : host_port_checker
bind parallel_host_bus_port host_port_checker host_port_checker_inst (.*);
`default_nettype wire

// File: test/tb_top.sv
`include "host_port_params.svh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import host_port_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	bus_mode_type bus_mode;
	logic chip_select_low_n, read_strobe_low_n, write_strobe_or_direction, data_oe, ok;
	logic transfer_acknowledge, transfer_acknowledge_oe;
	logic [`ADDR_WIDTH-1:0] addr_in;
	logic [`DATA_WIDTH-1:0] data_in, data_out, q;
	int n_fail = 0, n_tests = 0, cyc = 0;
	always #50 sys_clk = ~sys_clk;
	parallel_host_bus_port parallel_host_bus_port_inst (.*);
	host_model host_model_inst (.*);
	task automatic chk(input logic [`DATA_WIDTH-1:0] g, e);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic go(input bus_mode_type m, input logic w, input logic [`ADDR_WIDTH-1:0] a,
		input logic [`DATA_WIDTH-1:0] d);
		host_model_inst.xfer(m, w, a, d, q, ok);
		chk(8'(ok), 8'h01);
	endtask : go
	task automatic t_strobed;
		chk(8'(transfer_acknowledge_oe), 8'h00);
		go(mode_strobed, 1'b1, 7'h7F, 8'hA5);
		go(mode_strobed, 1'b1, 7'h00, 8'h5A);
		go(mode_strobed, 1'b0, 7'h7F, 8'h00);
		chk(q, 8'hA5);
		go(mode_strobed, 1'b0, 7'h00, 8'h00);
		chk(q, 8'h5A);
	endtask : t_strobed
	task automatic t_split;
		go(mode_split, 1'b1, 7'h01, 8'h3C);
		go(mode_split, 1'b0, 7'h7F, 8'h00);
		chk(q, 8'hA5);
		go(mode_split, 1'b0, 7'h01, 8'h00);
		chk(q, 8'h3C);
		go(mode_strobed, 1'b0, 7'h01, 8'h00);
		chk(q, 8'h3C);
	endtask : t_split
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : test_done
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			n_fail++;
			test_done;
		end
	end
	initial begin
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_strobed;
		t_split;
		test_done;
	end
endmodule : tb_top
`default_nettype wire
